// file: verilog/fault_irq_params.svh
`ifndef FAULT_IRQ_PARAMS_SVH
`define FAULT_IRQ_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define SUPPLY_EN_IDX   8'h08
`define BOOST_EN_IDX    8'h0a
`define LED_EN_IDX      8'h0c
`define STATUS_IDX      8'h10
`define MASK_IDX        8'h11

// ----------------------------------------
// Reset values as read back
// ----------------------------------------
`define SUPPLY_EN_RST   16'h2aaa
`define BOOST_EN_RST    16'ha028
`define LED_EN_RST      16'h00aa
`define STATUS_RST      17'h00000
`define MASK_RST        17'h1ffff

// ----------------------------------------
// Field maps: one bit per two-bit field
// ----------------------------------------
`define SUPPLY_FIELDS   8'h7f
`define BOOST_FIELDS    8'hfe
`define LED_FIELDS      8'h0f
`define SUPPLY_EN_INIT  8'h7f
`define BOOST_EN_INIT   8'hc6
`define LED_EN_INIT     8'h0f
`define GLOBAL_FIELD    3

// ----------------------------------------
// Field codes and bus answers
// ----------------------------------------
`define CODE_DISABLE    2'h1
`define CODE_ENABLE     2'h3
`define READ_ON         2'h2
`define READ_OFF        2'h0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: verilog/fault_irq_pkg.sv
package fault_irq_pkg;

	typedef logic [7:0]  field_bits_t;
	typedef logic [16:0] source_vec_t;

	typedef enum {SEL_SUPPLY, SEL_BOOST, SEL_LED, SEL_STATUS, SEL_MASK, SEL_NONE} reg_sel_e;
	typedef enum {PH_IDLE, PH_RESP} phase_e;

endpackage

// file: verilog/field_wr_if.sv
`timescale 1ns/100ps

interface field_wr_if;
	import fault_irq_pkg::*;

	logic                     wr;
	logic [15:0]              wdata;
	logic [1:0]               strb;
	field_bits_t              en;

	modport ctrl (output wr, output wdata, output strb, input en);
	modport bank (input wr, input wdata, input strb, output en);
endinterface

// file: verilog/enable_field_bank.sv
`timescale 1ns/100ps
`include "fault_irq_params.svh"

module enable_field_bank
	import fault_irq_pkg::*;
#(
	parameter field_bits_t FIELDS   = 8'hff,
	parameter field_bits_t RESET_EN = 8'h00
)
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	field_wr_if.bank          port
);

	field_bits_t en_ff;
	field_bits_t nxt_en;
	field_bits_t hit_on;
	field_bits_t hit_off;

	// Codes 0h and 2h leave a field alone, so a full write of read-back data is harmless
	always_comb begin
		hit_on  = '0;
		hit_off = '0;
		for (int i = 0; i < 8; i++) begin
			if (port.wr && port.strb[i/4] && FIELDS[i]) begin
				hit_on[i]  = (port.wdata[2*i+:2] == `CODE_ENABLE);
				hit_off[i] = (port.wdata[2*i+:2] == `CODE_DISABLE);
			end
		end
		nxt_en = (en_ff | hit_on) & ~hit_off;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_ff <= RESET_EN & FIELDS;
		end else begin
			en_ff <= nxt_en;
		end
	end

	assign port.en = en_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_disable_code: assert property (hit_off != 0 |=> (en_ff & $past(hit_off)) == 0)
		else $error("disable code did not clear the enable");
	a_enable_code: assert property (hit_on != 0 |=> (en_ff & $past(hit_on)) == $past(hit_on))
		else $error("enable code did not set the enable");
	a_other_codes_hold: assert property (##1 ((en_ff ^ $past(en_ff)) & ~$past(hit_on | hit_off)) == 0)
		else $error("field changed without a set or clear code");
	a_spare_fields_zero: assert property ((en_ff & ~FIELDS) == 0)
		else $error("reserved field holds an enable");
endmodule

// file: verilog/irq_status_unit.sv
`timescale 1ns/100ps
`include "fault_irq_params.svh"

module irq_status_unit
	import fault_irq_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire source_vec_t  events,
	input  wire source_vec_t  src_en,
	input  wire logic         global_en,
	input  wire logic         clr_wr,
	input  wire logic         mask_wr,
	input  wire source_vec_t  wr_bits,
	input  wire source_vec_t  wr_lanes,
	output source_vec_t       status,
	output source_vec_t       mask,
	output logic              irq
);

	source_vec_t status_ff;
	source_vec_t nxt_status;
	source_vec_t mask_ff;
	source_vec_t nxt_mask;
	logic        irq_ff;
	logic        nxt_irq;

	// A new event in the clearing cycle survives: set is ORed in after the clear
	always_comb begin
		nxt_status = status_ff;
		if (clr_wr) begin
			nxt_status = status_ff & ~(wr_bits & wr_lanes);
		end
		nxt_status = nxt_status | events;
		nxt_mask   = mask_ff;
		if (mask_wr) begin
			nxt_mask = (mask_ff & ~wr_lanes) | (wr_bits & wr_lanes);
		end
		nxt_irq = global_en && ((status_ff & mask_ff & src_en) != 0);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_ff <= `STATUS_RST;
			mask_ff   <= `MASK_RST;
			irq_ff    <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			mask_ff   <= nxt_mask;
			irq_ff    <= nxt_irq;
		end
	end

	assign status = status_ff;
	assign mask   = mask_ff;
	assign irq    = irq_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_global_gate: assert property (!global_en |=> !irq_ff)
		else $error("interrupt raised while global enable off");
	a_irq_cause: assert property (irq_ff |-> $past(global_en) && ($past(status_ff & mask_ff & src_en) != 0))
		else $error("interrupt raised without an enabled pending fault");
	a_event_sticky: assert property (events != 0 |=> (status_ff & $past(events)) == $past(events))
		else $error("event lost from status");
	c_irq_rise: cover property ($rose(irq_ff));
endmodule

// file: verilog/fault_irq_enable_bank.sv
`timescale 1ns/100ps
`include "fault_irq_params.svh"

// Operation
// - each enable field reads 0h when disabled and 2h when enabled.
// - writing 1h disables a source, writing 3h enables it.
// - supply register holds six supply fault enables in bits 11-0, reset enabled.
// - boost register sits at index 0Ah and resets to A028h.
// - thermal shutdown and current resistor short enables at 15-14, 13-12, reset enabled.
// - three missing-resistor enables at 11-10, 9-8, 7-6 reset disabled.
// - boost overcurrent and overvoltage enables at 5-4 and 3-2, reset enabled.
// - boost bits 1-0 and LED bits 15-8 reserved, zero, no function.
// - LED register sits at index 0Ch and resets to AAh.
// - global enable at LED bits 7-6 gates all interrupt reporting.
// - serial bus timeout enable at LED bits 5-4, reset enabled.
// - bad string config at 3-2 and string fault at 1-0, reset enabled.
// - supply register at index 08h, reset 2AAAh, boost sync enable at 13-12.

module fault_irq_enable_bank
	import fault_irq_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         awvalid,
	output logic              awready,
	input  wire logic [7:0]   awaddr,
	input  wire logic         wvalid,
	output logic              wready,
	input  wire logic [31:0]  wdata,
	input  wire logic [3:0]   wstrb,
	output logic              bvalid,
	input  wire logic         bready,
	output logic [1:0]        bresp,
	input  wire logic         arvalid,
	output logic              arready,
	input  wire logic [7:0]   araddr,
	output logic              rvalid,
	input  wire logic         rready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	input  wire source_vec_t  fault_events,
	output logic              irq
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic reg_sel_e decode(input logic [7:0] addr);
		reg_sel_e sel;
		sel = SEL_NONE;
		if (addr[1:0] == 2'h0) begin
			if ({2'h0, addr[7:2]} == `SUPPLY_EN_IDX) sel = SEL_SUPPLY;
			if ({2'h0, addr[7:2]} == `BOOST_EN_IDX)  sel = SEL_BOOST;
			if ({2'h0, addr[7:2]} == `LED_EN_IDX)    sel = SEL_LED;
			if ({2'h0, addr[7:2]} == `STATUS_IDX)    sel = SEL_STATUS;
			if ({2'h0, addr[7:2]} == `MASK_IDX)      sel = SEL_MASK;
		end
		return sel;
	endfunction

	// Reserved positions are masked by the field map, so they always read zero
	function automatic logic [15:0] expand(input field_bits_t en, input field_bits_t fields);
		logic [15:0] v;
		v = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			v[2*i+:2] = (fields[i] && en[i]) ? `READ_ON : `READ_OFF;
		end
		return v;
	endfunction

	function automatic logic [31:0] lanes(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			m[8*b+:8] = {8{strb[b]}};
		end
		return m;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	phase_e      wr_phase_ff;
	phase_e      nxt_wr_phase;
	phase_e      rd_phase_ff;
	phase_e      nxt_rd_phase;
	logic        aw_held_ff;
	logic        nxt_aw_held;
	logic        w_held_ff;
	logic        nxt_w_held;
	logic [7:0]  awaddr_ff;
	logic [7:0]  nxt_awaddr;
	logic [31:0] wdata_ff;
	logic [31:0] nxt_wdata;
	logic [3:0]  wstrb_ff;
	logic [3:0]  nxt_wstrb;
	logic        awready_ff;
	logic        wready_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic [1:0]  nxt_bresp;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [1:0]  rresp_ff;
	logic [1:0]  nxt_rresp;
	logic        rd_enreg_ff;
	logic        nxt_rd_enreg;
	logic        commit;
	reg_sel_e    wsel;
	reg_sel_e    rsel;
	logic [31:0] wlanes;

	logic [15:0] supply_rd;
	logic [15:0] boost_rd;
	logic [15:0] led_rd;
	source_vec_t src_en;
	source_vec_t status;
	source_vec_t mask;
	logic        irq_q;

	field_wr_if sup_if ();
	field_wr_if bst_if ();
	field_wr_if led_if ();

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	// Address and data are caught in either order; the write lands when both are held
	always_comb begin
		nxt_aw_held  = aw_held_ff;
		nxt_w_held   = w_held_ff;
		nxt_awaddr   = awaddr_ff;
		nxt_wdata    = wdata_ff;
		nxt_wstrb    = wstrb_ff;
		nxt_wr_phase = wr_phase_ff;
		nxt_bresp    = bresp_ff;
		commit       = 1'b0;
		wsel         = decode(awaddr_ff);
		if (awvalid && awready_ff) begin
			nxt_aw_held = 1'b1;
			nxt_awaddr  = awaddr;
		end
		if (wvalid && wready_ff) begin
			nxt_w_held = 1'b1;
			nxt_wdata  = wdata;
			nxt_wstrb  = wstrb;
		end
		case (wr_phase_ff)
			PH_IDLE: begin
				if (aw_held_ff && w_held_ff) begin
					commit       = 1'b1;
					nxt_aw_held  = 1'b0;
					nxt_w_held   = 1'b0;
					nxt_bresp    = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
					nxt_wr_phase = PH_RESP;
				end
			end
			PH_RESP: begin
				if (bready) begin
					nxt_wr_phase = PH_IDLE;
				end
			end
			default: begin
				nxt_wr_phase = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_phase_ff <= PH_IDLE;
			aw_held_ff  <= 1'b0;
			w_held_ff   <= 1'b0;
			awaddr_ff   <= 8'h00;
			wdata_ff    <= 32'h0000_0000;
			wstrb_ff    <= 4'h0;
			awready_ff  <= 1'b0;
			wready_ff   <= 1'b0;
			bvalid_ff   <= 1'b0;
			bresp_ff    <= `RESP_OKAY;
		end else begin
			wr_phase_ff <= nxt_wr_phase;
			aw_held_ff  <= nxt_aw_held;
			w_held_ff   <= nxt_w_held;
			awaddr_ff   <= nxt_awaddr;
			wdata_ff    <= nxt_wdata;
			wstrb_ff    <= nxt_wstrb;
			awready_ff  <= !nxt_aw_held;
			wready_ff   <= !nxt_w_held;
			bvalid_ff   <= (nxt_wr_phase == PH_RESP);
			bresp_ff    <= nxt_bresp;
		end
	end

	assign wlanes = lanes(wstrb_ff);

	assign sup_if.wr    = commit && (wsel == SEL_SUPPLY);
	assign sup_if.wdata = wdata_ff[15:0];
	assign sup_if.strb  = wstrb_ff[1:0];
	assign bst_if.wr    = commit && (wsel == SEL_BOOST);
	assign bst_if.wdata = wdata_ff[15:0];
	assign bst_if.strb  = wstrb_ff[1:0];
	assign led_if.wr    = commit && (wsel == SEL_LED);
	assign led_if.wdata = wdata_ff[15:0];
	assign led_if.strb  = wstrb_ff[1:0];

	// ----------------------------------------
	// Enable banks
	// ----------------------------------------
	enable_field_bank #(.FIELDS(`SUPPLY_FIELDS), .RESET_EN(`SUPPLY_EN_INIT)) u_supply (
		.aclk    (aclk),
		.aresetn (aresetn),
		.port    (sup_if.bank)
	);

	enable_field_bank #(.FIELDS(`BOOST_FIELDS), .RESET_EN(`BOOST_EN_INIT)) u_boost (
		.aclk    (aclk),
		.aresetn (aresetn),
		.port    (bst_if.bank)
	);

	enable_field_bank #(.FIELDS(`LED_FIELDS), .RESET_EN(`LED_EN_INIT)) u_led (
		.aclk    (aclk),
		.aresetn (aresetn),
		.port    (led_if.bank)
	);

	assign supply_rd = expand(sup_if.en, `SUPPLY_FIELDS);
	assign boost_rd  = expand(bst_if.en, `BOOST_FIELDS);
	assign led_rd    = expand(led_if.en, `LED_FIELDS);

	// Status order: supply fields 0-6, boost fields 1-7, LED fields 0-2
	assign src_en = {led_if.en[2:0], bst_if.en[7:1], sup_if.en[6:0]};

	// ----------------------------------------
	// Pending faults and interrupt
	// ----------------------------------------
	irq_status_unit u_irq (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.events    (fault_events),
		.src_en    (src_en),
		.global_en (led_if.en[`GLOBAL_FIELD]),
		.clr_wr    (commit && (wsel == SEL_STATUS)),
		.mask_wr   (commit && (wsel == SEL_MASK)),
		.wr_bits   (wdata_ff[16:0]),
		.wr_lanes  (wlanes[16:0]),
		.status    (status),
		.mask      (mask),
		.irq       (irq_q)
	);

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always_comb begin
		nxt_rd_phase = rd_phase_ff;
		nxt_rdata    = rdata_ff;
		nxt_rresp    = rresp_ff;
		nxt_rd_enreg = rd_enreg_ff;
		rsel         = decode(araddr);
		case (rd_phase_ff)
			PH_IDLE: begin
				if (arvalid && arready_ff) begin
					nxt_rd_phase = PH_RESP;
					nxt_rresp    = `RESP_OKAY;
					nxt_rd_enreg = (rsel == SEL_SUPPLY) || (rsel == SEL_BOOST) || (rsel == SEL_LED);
					case (rsel)
						SEL_SUPPLY: nxt_rdata = {16'h0000, supply_rd};
						SEL_BOOST:  nxt_rdata = {16'h0000, boost_rd};
						SEL_LED:    nxt_rdata = {16'h0000, led_rd};
						SEL_STATUS: nxt_rdata = {15'h0000, status};
						SEL_MASK:   nxt_rdata = {15'h0000, mask};
						default: begin
							nxt_rdata = 32'h0000_0000;
							nxt_rresp = `RESP_SLVERR;
						end
					endcase
				end
			end
			PH_RESP: begin
				if (rready) begin
					nxt_rd_phase = PH_IDLE;
				end
			end
			default: begin
				nxt_rd_phase = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_phase_ff <= PH_IDLE;
			arready_ff  <= 1'b0;
			rvalid_ff   <= 1'b0;
			rdata_ff    <= 32'h0000_0000;
			rresp_ff    <= `RESP_OKAY;
			rd_enreg_ff <= 1'b0;
		end else begin
			rd_phase_ff <= nxt_rd_phase;
			arready_ff  <= (nxt_rd_phase == PH_IDLE);
			rvalid_ff   <= (nxt_rd_phase == PH_RESP);
			rdata_ff    <= nxt_rdata;
			rresp_ff    <= nxt_rresp;
			rd_enreg_ff <= nxt_rd_enreg;
		end
	end

	assign awready = awready_ff;
	assign wready  = wready_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign arready = arready_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;
	assign irq     = irq_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_readback_codes: assert property (rvalid_ff && rd_enreg_ff |-> (rdata_ff & 32'h0000_5555) == 0)
		else $error("enable field read back an odd code");
	a_reset_supply: assert property ($past(!aresetn) |-> supply_rd == `SUPPLY_EN_RST)
		else $error("supply enables wrong after reset");
	a_reset_boost: assert property ($past(!aresetn) |-> boost_rd == `BOOST_EN_RST)
		else $error("boost enables wrong after reset");
	a_reset_led: assert property ($past(!aresetn) |-> led_rd == `LED_EN_RST)
		else $error("LED enables wrong after reset");
	a_reserved_bits: assert property (boost_rd[1:0] == 2'h0 && led_rd[15:8] == 8'h00)
		else $error("reserved bits read nonzero");
	a_write_answer: assert property (commit |=> bvalid_ff && (bresp_ff == ((wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY)) [*1])
		else $error("write answer missing or wrong");
	a_bresp_hold: assert property (bvalid_ff && !bready |=> bvalid_ff && $stable(bresp_ff))
		else $error("write response dropped before bready");
	a_rdata_hold: assert property (rvalid_ff && !rready |=> rvalid_ff && $stable(rdata_ff))
		else $error("read data changed before rready");

	c_enable_write: cover property (commit && wsel == SEL_LED);
	c_bad_read: cover property (rvalid_ff && rresp_ff == `RESP_SLVERR);
	c_status_clear: cover property (commit && wsel == SEL_STATUS && status != 0);
endmodule

// file: tb/fault_irq_enable_bank_tb.sv
`timescale 1ns/100ps

module fault_irq_enable_bank_tb
	import fault_irq_pkg::*;
;
	logic        aclk;
	logic        aresetn;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, d;
	logic [3:0]  wstrb, s;
	logic [1:0]  bresp, rresp, rsp;
	source_vec_t fault_events;
	int          n_errors, check_count, cyc, ri;
	logic [15:0] exp_en [3];
	logic [16:0] exp_mask;
	logic [7:0]  base [3] = '{8'h20, 8'h28, 8'h30};
	logic [7:0]  fmap [3] = '{8'h7f, 8'hfe, 8'h0f};
	logic [15:0] rstv [3] = '{16'h2aaa, 16'ha028, 16'h00aa};
	logic [31:0] corner [4] = '{32'hffffffff, 32'h55555555, 32'haaaaaaaa, 32'h00000000};

	fault_irq_enable_bank i_fault_irq_enable_bank (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.awvalid      (awvalid),
		.awready      (awready),
		.awaddr       (awaddr),
		.wvalid       (wvalid),
		.wready       (wready),
		.wdata        (wdata),
		.wstrb        (wstrb),
		.bvalid       (bvalid),
		.bready       (bready),
		.bresp        (bresp),
		.arvalid      (arvalid),
		.arready      (arready),
		.araddr       (araddr),
		.rvalid       (rvalid),
		.rready       (rready),
		.rdata        (rdata),
		.rresp        (rresp),
		.fault_events (fault_events),
		.irq          (irq)
	);

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			close_out();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Model of one enable register: only codes 1h and 3h move a field
	function automatic logic [15:0] upd(logic [15:0] cur, logic [15:0] v, logic [1:0] st, logic [7:0] f);
		logic [15:0] n;
		n = cur;
		for (int k = 0; k < 8; k++) begin
			if (f[k] && st[k / 4] && v[2 * k +: 2] == 2'h1) n[2 * k +: 2] = 2'h0;
			if (f[k] && st[k / 4] && v[2 * k +: 2] == 2'h3) n[2 * k +: 2] = 2'h2;
		end
		return n;
	endfunction

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= v;
		wstrb   <= st;
		bready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		exp_en   = rstv;
		exp_mask = 17'h1ffff;
	endtask

	task automatic check_resets();
		for (int r = 0; r < 3; r++) begin
			axi_rd(base[r], rd, rsp);
			chk(rd, {16'h0, rstv[r]});
			chk({30'h0, rsp}, 32'h0);
		end
		axi_rd(8'h40, rd, rsp);
		chk(rd, 32'h0);
		axi_rd(8'h44, rd, rsp);
		chk(rd, 32'h0001ffff);
		$display("test reset values done");
	endtask

	task automatic wr_field(input int r, input int f, input logic on);
		logic [15:0] v;
		v = 16'(on ? 2'h3 : 2'h1) << (2 * f);
		axi_wr(base[r], {16'h0, v}, 4'h3, rsp);
		exp_en[r] = upd(exp_en[r], v, 2'h3, fmap[r]);
	endtask

	// Event order follows the status bits: supply, boost, then LED fields
	task automatic irq_case(input int i);
		int   r;
		int   f;
		logic en;
		logic m;
		logic g;
		r  = (i < 7) ? 0 : (i < 14) ? 1 : 2;
		f  = (i < 7) ? i : (i < 14) ? i - 6 : i - 14;
		en = ($urandom % 4) != 0;
		m  = ($urandom % 4) != 0;
		g  = ($urandom % 4) != 0;
		wr_field(r, f, en);
		wr_field(2, 3, g);
		exp_mask    = 17'($urandom);
		exp_mask[i] = m;
		axi_wr(8'h44, {15'h0, exp_mask}, 4'hf, rsp);
		@(posedge aclk);
		fault_events <= 17'h1 << i;
		@(posedge aclk);
		fault_events <= '0;
		repeat (2) @(posedge aclk);
		#1 chk({31'h0, irq}, {31'h0, en & m & g});
		axi_rd(8'h40, rd, rsp);
		chk(rd, 32'(17'h1 << i));
		if (en & m & g) begin
			wr_field(r, f, 1'b0);
			@(posedge aclk);
			#1 chk({31'h0, irq}, 32'h0);
		end
		axi_wr(8'h40, 32'(17'h1 << i), 4'hf, rsp);
		axi_rd(8'h40, rd, rsp);
		chk(rd, 32'h0);
		#1 chk({31'h0, irq}, 32'h0);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		aresetn      = 1'b0;
		awvalid      = 1'b0;
		wvalid       = 1'b0;
		bready       = 1'b0;
		arvalid      = 1'b0;
		rready       = 1'b0;
		awaddr       = 8'h00;
		araddr       = 8'h00;
		wdata        = 32'h0;
		wstrb        = 4'h0;
		fault_events = '0;
		n_errors     = 0;
		check_count  = 0;
		cyc          = 0;
		void'($urandom(58886));
		do_reset();
		check_resets();
		for (int n = 0; n < 60; n++) begin
			ri = $urandom % 3;
			d  = (n < 8) ? corner[n % 4] : $urandom;
			s  = (n < 8) ? 4'hf : 4'($urandom);
			axi_wr(base[ri], d, s, rsp);
			chk({30'h0, rsp}, 32'h0);
			exp_en[ri] = upd(exp_en[ri], d[15:0], s[1:0], fmap[ri]);
			axi_rd(base[ri], rd, rsp);
			chk(rd, {16'h0, exp_en[ri]});
		end
		$display("test field codes done");
		axi_rd(8'h3c, rd, rsp);
		chk(rd, 32'h0);
		chk({30'h0, rsp}, 32'h2);
		axi_wr(8'h22, 32'hffffffff, 4'hf, rsp);
		chk({30'h0, rsp}, 32'h2);
		axi_rd(8'h20, rd, rsp);
		chk(rd, {16'h0, exp_en[0]});
		$display("test bad address done");
		// A second reset mid-run must bring every register back
		do_reset();
		check_resets();
		for (int i = 0; i < 17; i++) begin
			irq_case(i);
		end
		$display("test interrupt gating done");
		close_out();
	end
endmodule
